// [rtl/pmic_consts.svh]
// Constants for the projector power-controller serial link and its host
`ifndef PMIC_CONSTS_SVH
`define PMIC_CONSTS_SVH
// Device register map
`define REG_CHIP_ID 7'h00
`define REG_ENABLE 7'h01
`define REG_STATUS 7'h0c
`define REG_MASK 7'h0d
`define REG_KEY 7'h10
`define REG_PROT_LO 7'h11
`define REG_PROT_HI 7'h27
`define REG_COUNT 7'h28
// Enable register fields and reset values
`define EN_ARRAY_BIT 1
`define EN_LED_BIT 0
`define ENABLE_RST 8'h0d
`define MASK_RST 8'hdf
// Unlock key bytes and key readback
`define KEY_FIRST 8'hba
`define KEY_SECOND 8'hbe
`define KEY_RD_LOCKED 8'h00
`define KEY_RD_UNLOCKED 8'h01
// Status bit positions
`define ST_LED_OVP 0
`define ST_LS_LOW 1
`define ST_SUPPLY_UV 2
`define ST_TSD 3
`define ST_UVLO 4
// Interrupt release window after a status read
`define CLK_MHZ 100
`define IRQ_REPULL_MAX_US 32
`define IRQ_HOLD_US 16
`define IRQ_HOLD_CYC (`IRQ_HOLD_US * `CLK_MHZ)
// Host serial clock: eight system clocks per bit
`define SCLK_HALF 3'd4
`define SCLK_LAST 3'd7
// Host Wishbone register offsets (byte addresses)
`define HOST_CTRL 4'h0
`define HOST_STATUS 4'h4
`define HOST_POWER 4'h8
`endif

// [rtl/pmic_pkg.sv]
// Types for the power-controller link ends
package pmic_pkg;
    typedef enum logic [1:0] {
        off_state,
        standby_state,
        array_only_state,
        array_and_led_state
    } mode_t;

    typedef enum logic {
        host_idle,
        host_run
    } host_mode_t;

    typedef struct packed {
        logic [1:0] pon_s;
        logic [2:0] sclk_s;
        logic [1:0] cs_s;
        logic [1:0] din_s;
        logic [4:0] flt_s1;
        logic [4:0] flt_s2;
        mode_t mode;
        logic pg_lock;
        logic [2:0] bitcnt;
        logic first;
        logic write_not_read_flag;
        logic [6:0] addr;
        logic [7:0] sr;
        logic [7:0] tx;
        logic dout;
        logic dout_oe;
        logic key_stage;
        logic unlocked;
        logic [39:0][7:0] mem;
        logic [7:0] status;
        logic [10:0] hold;
        logic irq_oe;
        logic sup_en;
        logic led_en;
        logic fast_sd;
        logic rst_n_out;
    } dev_state_t;

    typedef struct packed {
        host_mode_t mode;
        logic cs_n;
        logic sclk;
        logic mosi;
        logic [15:0] sh;
        logic [7:0] rx;
        logic [2:0] cnt;
        logic [3:0] bitn;
        logic pon;
        logic ack;
        logic [31:0] dat;
        logic [1:0] miso_s;
        logic [1:0] irq_s;
    } host_state_t;
endpackage

// [rtl/pmic_if.sv]
// Pins between the power controller and its host
`timescale 1ns/10ps
interface pmic_if;
    logic sclk;
    logic serial_select_n;
    logic mosi;
    logic miso;
    logic miso_oe;
    logic power_on_pin;
    logic irq_oe;
    logic miso_line;
    logic irq_out_n;

    // Pulled-up lines resolved from the enables
    assign miso_line = miso_oe ? miso : 1'b1;
    assign irq_out_n = irq_oe ? 1'b0 : 1'b1;

    modport device (
        input sclk, serial_select_n, mosi, power_on_pin,
        output miso, miso_oe, irq_oe
    );
    modport host (
        output sclk, serial_select_n, mosi, power_on_pin,
        input miso_line, irq_out_n
    );
endinterface

// [rtl/pmic_device.sv]
// Device end: serial registers, unlock, interrupts, power modes
//
// Decided for this implementation: the chip ID value.
`timescale 1ns/10ps
`include "pmic_consts.svh"
module pmic_device
    import pmic_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Link pins
    pmic_if.device link,
    // Fault detector levels
    input wire logic led_ovp_i,
    input wire logic ls_low_i,
    input wire logic supply_uv_i,
    input wire logic tsd_i,
    input wire logic uvlo_i,
    // Power controls
    output logic array_supply_en_o,
    output logic led_power_en_o,
    output logic fast_shutdown_o,
    output logic array_reset_out_n_o
);
    localparam logic [7:0] CHIP_ID = 8'h5a; // Arbitrary value

    dev_state_t q, n;

    function automatic dev_state_t dev_rst();
        dev_state_t r;
        r = '0;
        r.mode = off_state;
        r.first = 1'b1;
        // Idle levels, so no false edge follows reset
        r.sclk_s = 3'b111;
        r.cs_s = 2'b11;
        r.mem[`REG_ENABLE] = `ENABLE_RST;
        r.mem[`REG_MASK] = `MASK_RST;
        return r;
    endfunction

    function automatic logic prot(input logic [6:0] a);
        return (a >= `REG_PROT_LO) && (a <= `REG_PROT_HI);
    endfunction

    function automatic logic [7:0] rd(input dev_state_t s,
                                      input logic [6:0] a);
        if (a == `REG_CHIP_ID) begin
            return CHIP_ID;
        end else if (a == `REG_STATUS) begin
            return s.status;
        end else if (a == `REG_KEY) begin
            return s.unlocked ? `KEY_RD_UNLOCKED : `KEY_RD_LOCKED;
        end else if (a < `REG_COUNT) begin
            return s.mem[a[5:0]];
        end
        return 8'h00;
    endfunction

    logic rise, fall, pon, cs_act, clr, fault;
    logic [7:0] byte_in, ev;
    logic [6:0] nxt;
    logic [4:0] flt;

    // Next-state logic for the whole device
    always_comb begin
        n = q;
        clr = 1'b0;
        byte_in = {q.sr[6:0], q.din_s[1]};
        nxt = q.addr + 7'h01;
        n.pon_s = {q.pon_s[0], link.power_on_pin};
        n.sclk_s = {q.sclk_s[1:0], link.sclk};
        n.cs_s = {q.cs_s[0], link.serial_select_n};
        n.din_s = {q.din_s[0], link.mosi};
        n.flt_s1 = {uvlo_i, tsd_i, supply_uv_i, ls_low_i, led_ovp_i};
        n.flt_s2 = q.flt_s1;
        rise = q.sclk_s[1] & ~q.sclk_s[2];
        fall = ~q.sclk_s[1] & q.sclk_s[2];
        pon = q.pon_s[1];
        cs_act = ~q.cs_s[1];
        flt = q.flt_s2;
        ev = {3'b000, flt};
        fault = flt[`ST_SUPPLY_UV] | flt[`ST_TSD] | flt[`ST_UVLO];
        if (!pon) begin
            // Off: everything but the pin and fault synchronisers to defaults, link ignored
            n = dev_rst();
            n.pon_s = {q.pon_s[0], link.power_on_pin};
            n.sclk_s = {q.sclk_s[1:0], link.sclk};
            n.cs_s = {q.cs_s[0], link.serial_select_n};
            n.din_s = {q.din_s[0], link.mosi};
            n.flt_s1 = {uvlo_i, tsd_i, supply_uv_i, ls_low_i, led_ovp_i};
            n.flt_s2 = q.flt_s1;
        end else begin
            if (!cs_act) begin
                // Deselected: framing restarts, output floats
                n.bitcnt = 3'd0;
                n.first = 1'b1;
                n.dout_oe = 1'b0;
            end else begin
                n.dout_oe = 1'b1;
                if (rise) begin
                    n.sr = byte_in;
                    n.bitcnt = q.bitcnt + 3'd1;
                    if (q.bitcnt == 3'd7 && q.first) begin
                        n.first = 1'b0;
                        n.write_not_read_flag = byte_in[7];
                        n.addr = byte_in[6:0];
                        if (!byte_in[7]) begin
                            n.tx = rd(q, byte_in[6:0]);
                            clr = (byte_in[6:0] == `REG_STATUS);
                        end
                    end else if (q.bitcnt == 3'd7) begin
                        n.addr = nxt;
                        n.key_stage = 1'b0;
                        if (q.write_not_read_flag && q.addr == `REG_KEY) begin
                            if (byte_in == `KEY_SECOND && q.key_stage) begin
                                n.unlocked = 1'b1;
                            end else if (byte_in != `KEY_FIRST) begin
                                n.unlocked = 1'b0;
                            end
                            n.key_stage = (byte_in == `KEY_FIRST);
                        end else if (q.write_not_read_flag) begin
                            // Read-only and unimplemented bytes drop writes
                            if (q.addr < `REG_COUNT &&
                                q.addr != `REG_CHIP_ID &&
                                q.addr != `REG_STATUS &&
                                (!prot(q.addr) || q.unlocked)) begin
                                n.mem[q.addr[5:0]] = byte_in;
                            end
                        end else begin
                            n.tx = rd(q, nxt);
                            clr = (nxt == `REG_STATUS);
                        end
                    end
                end
                if (fall) begin
                    n.dout = q.tx[7];
                    n.tx = {q.tx[6:0], 1'b0};
                end
            end
            // Read clears; a live fault sets again in the same cycle
            n.status = (clr ? 8'h00 : q.status) | ev;
            if (clr) begin
                n.hold = 11'(`IRQ_HOLD_CYC);
            end else if (q.hold != 11'd0) begin
                n.hold = q.hold - 11'd1;
            end
            // Mask reaches the pin only, never the status bits
            n.irq_oe = (|(q.status & ~q.mem[`REG_MASK])) &&
                       (q.hold == 11'd0) && !clr;
            if (flt[`ST_LS_LOW]) begin
                n.pg_lock = 1'b1;
            end
            if (fault) begin
                n.mem[`REG_ENABLE][`EN_ARRAY_BIT] = 1'b0;
            end
            // Mode selection; LED overvoltage is not a shutdown cause
            if (q.pg_lock || fault ||
                !q.mem[`REG_ENABLE][`EN_ARRAY_BIT]) begin
                n.mode = standby_state;
            end else if (q.mem[`REG_ENABLE][`EN_LED_BIT]) begin
                n.mode = array_and_led_state;
            end else begin
                n.mode = array_only_state;
            end
            n.fast_sd = q.pg_lock | flt[`ST_LS_LOW];
            n.sup_en = (q.mode == array_only_state ||
                        q.mode == array_and_led_state) &&
                       !flt[`ST_LS_LOW] && !q.pg_lock;
            n.led_en = (q.mode == array_and_led_state) && !q.pg_lock;
            n.rst_n_out = 1'b1;
        end
    end

    // State register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= dev_rst();
        end else begin
            q <= n;
        end
    end

    // Outputs straight from flops
    assign link.miso = q.dout;
    assign link.miso_oe = q.dout_oe;
    assign link.irq_oe = q.irq_oe;
    assign array_supply_en_o = q.sup_en;
    assign led_power_en_o = q.led_en;
    assign fast_shutdown_o = q.fast_sd;
    assign array_reset_out_n_o = q.rst_n_out;
endmodule

// [rtl/pmic_host.sv]
// Host end: Wishbone-commanded serial master and power-on control
`timescale 1ns/10ps
`include "pmic_consts.svh"
module pmic_host
    import pmic_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [3:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Link pins
    pmic_if.host link
);
    host_state_t q, n;

    // Next-state logic
    always_comb begin
        n = q;
        n.ack = 1'b0;
        n.miso_s = {q.miso_s[0], link.miso_line};
        n.irq_s = {q.irq_s[0], link.irq_out_n};
        if (cyc_i && stb_i && !q.ack) begin
            n.ack = 1'b1;
            n.dat = 32'h0000_0000;
            unique case (adr_i)
                `HOST_CTRL: begin
                    n.dat = {16'h0000, q.sh};
                    // Start only when idle and both lanes given
                    if (we_i && sel_i[1:0] == 2'b11 &&
                        q.mode == host_idle) begin
                        n.sh = dat_i[15:0];
                        n.mode = host_run;
                        n.cs_n = 1'b0;
                        n.cnt = 3'd0;
                        n.bitn = 4'd0;
                    end
                end
                `HOST_STATUS: begin
                    n.dat = {16'h0000, q.rx, 5'h00, ~q.irq_s[1],
                             q.pon, q.mode == host_run};
                end
                `HOST_POWER: begin
                    n.dat = {31'h0000_0000, q.pon};
                    if (we_i && sel_i[0]) begin
                        n.pon = dat_i[0];
                    end
                end
                default: n.dat = 32'h0000_0000;
            endcase
        end
        if (q.mode == host_run) begin
            n.cnt = q.cnt + 3'd1;
            if (q.cnt == 3'd0) begin
                // Change data while the clock is low
                n.sclk = 1'b0;
                n.mosi = q.sh[15];
                n.sh = {q.sh[14:0], 1'b0};
            end else if (q.cnt == `SCLK_HALF) begin
                n.sclk = 1'b1;
            end else if (q.cnt == `SCLK_LAST) begin
                // Late sample leaves room for both synchronisers
                if (q.bitn[3]) begin
                    n.rx = {q.rx[6:0], q.miso_s[1]};
                end
                n.bitn = q.bitn + 4'd1;
                if (q.bitn == 4'd15) begin
                    n.mode = host_idle;
                    n.cs_n = 1'b1;
                end
            end
        end
    end

    // State register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '{mode: host_idle, cs_n: 1'b1, sclk: 1'b1,
                   miso_s: 2'b11, irq_s: 2'b11, default: '0};
        end else begin
            q <= n;
        end
    end

    // Outputs straight from flops
    assign dat_o = q.dat;
    assign ack_o = q.ack;
    assign link.sclk = q.sclk;
    assign link.serial_select_n = q.cs_n;
    assign link.mosi = q.mosi;
    assign link.power_on_pin = q.pon;
endmodule

// [verif/pmic_link_chk.sv]
// Assertions on the link between the host and the device end
`timescale 1ns/10ps
module pmic_link_chk (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Link pins
    input wire logic sclk,
    input wire logic serial_select_n,
    input wire logic mosi,
    input wire logic miso_oe,
    input wire logic miso_line,
    input wire logic power_on_pin,
    input wire logic irq_oe
);
    logic sclk_q;
    logic [4:0] falls_q;

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // Serial clock falls inside one frame; cleared while deselected
    always_ff @(posedge clk_i) begin
        sclk_q <= sclk;
        if (rst_i || serial_select_n)
            falls_q <= 5'h00;
        else if (sclk_q && !sclk)
            falls_q <= falls_q + 5'h01;
    end

    // Sync delay of the select allows a few cycles before the float
    chk_miso_floats: assert property (
        serial_select_n [*5] |-> !miso_oe)
        else $error("miso driven while deselected");
    chk_sclk_idle: assert property (
        serial_select_n |-> sclk)
        else $error("serial clock low outside a frame");
    chk_mosi_on_fall: assert property (
        !serial_select_n && $changed(mosi) |-> $fell(sclk))
        else $error("mosi moved away from a falling clock");
    chk_sclk_low_half: assert property (
        $fell(sclk) |-> !sclk [*4] ##1 sclk)
        else $error("serial clock low phase not four cycles");
    chk_miso_settled: assert property (
        $rose(sclk) |=> $stable(miso_line) [*3])
        else $error("miso moved while clock high");
    chk_frame_bits: assert property (
        $rose(serial_select_n) |-> falls_q == 5'h10)
        else $error("frame not sixteen bits");
    chk_off_silent: assert property (
        !power_on_pin [*6] |-> !irq_oe && !miso_oe)
        else $error("pins driven in off mode");
    chk_irq_hold: assert property (
        $fell(irq_oe) |=> !irq_oe [*8])
        else $error("interrupt re-pulled at once");

    // Main scenarios reached
    cover property ($fell(irq_oe));
    cover property ($rose(serial_select_n));
    cover property ($rose(power_on_pin));
endmodule

// [verif/tb_pmic_serial_control_and_faults.sv]
// Bench: host and device joined, plus a device driven by the bench
`timescale 1ns/10ps
`include "pmic_consts.svh"
module tb_pmic_serial_control_and_faults;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [3:0] adr = 4'h0;
    logic [3:0] sel = 4'hf;
    logic [31:0] dw = 32'h0;
    logic [31:0] dr;
    logic ack, sup, led, fsd, arst;
    logic [4:0] flt = 5'h00;
    logic [7:0] txb [3];
    logic [7:0] rxb [3];
    int mismatches = 0;
    int checks = 0;
    pmic_if lk ();
    pmic_if lk2 ();

    pmic_host pmic_host_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
        .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dw),
        .dat_o(dr), .ack_o(ack), .link(lk));
    pmic_device pmic_device_inst (.clk_i(clk_i), .rst_i(rst_i), .link(lk),
        .led_ovp_i(flt[0]), .ls_low_i(flt[1]), .supply_uv_i(flt[2]),
        .tsd_i(flt[3]), .uvlo_i(flt[4]), .array_supply_en_o(sup),
        .led_power_en_o(led), .fast_shutdown_o(fsd),
        .array_reset_out_n_o(arst));
    // Second device: bench drives its link to reach multi-byte frames
    pmic_device pmic_device_inst2 (.clk_i(clk_i), .rst_i(rst_i),
        .link(lk2), .led_ovp_i(flt[0]), .ls_low_i(flt[1]),
        .supply_uv_i(flt[2]), .tsd_i(flt[3]), .uvlo_i(flt[4]),
        .array_supply_en_o(), .led_power_en_o(), .fast_shutdown_o(),
        .array_reset_out_n_o());
    pmic_link_chk pmic_link_chk_inst (.clk_i(clk_i), .rst_i(rst_i),
        .sclk(lk.sclk), .serial_select_n(lk.serial_select_n),
        .mosi(lk.mosi), .miso_oe(lk.miso_oe), .miso_line(lk.miso_line),
        .power_on_pin(lk.power_on_pin), .irq_oe(lk.irq_oe));

    // 100 MHz system clock
    always #5 clk_i = ~clk_i;

    task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e) begin
            mismatches++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task chkb(input string nm, input logic e, input logic g);
        chk(nm, {7'h0, e}, {7'h0, g});
    endtask
    task conclude;
        if (mismatches == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Classic single Wishbone cycle; waits for ack, bounded only by the watchdog
    task wb(input logic w, input logic [3:0] a, input logic [31:0] d,
        output logic [31:0] q);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'hf;
        dw <= d;
        // Only the watchdog ends a wait for the answer
        do begin
            @(posedge clk_i);
        end while (ack !== 1'b1);
        q = dr;
        cyc <= 1'b0;
        stb <= 1'b0;
        // Ack is a single-cycle pulse
        @(posedge clk_i);
        chkb("ack", 1'b0, ack);
    endtask
    task idle(output logic [31:0] q);
        do begin
            wb(1'b0, `HOST_STATUS, 32'h0, q);
        end while (q[0] !== 1'b0);
    endtask
    // One serial transfer through the host: command byte, one data byte
    task xfer(input logic [7:0] c, input logic [7:0] d,
        output logic [7:0] r);
        logic [31:0] q;
        idle(q);
        wb(1'b1, `HOST_CTRL, {16'h0, c, d}, q);
        idle(q);
        r = q[15:8];
        // Mode and power flops lag the last bit by a few cycles
        repeat (4) @(posedge clk_i);
    endtask
    task wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] r;
        xfer({1'b1, a}, d, r);
    endtask
    task rdc(input logic [6:0] a, input logic [7:0] e, input string nm);
        logic [7:0] r;
        xfer({1'b0, a}, 8'h00, r);
        chk(nm, e, r);
    endtask
    task pwr(input logic v);
        logic [31:0] q;
        wb(1'b1, `HOST_POWER, {31'h0, v}, q);
        repeat (10) @(posedge clk_i);
    endtask

    // Bench-side serial byte on the second link, 80 ns per bit
    task sbyte(input logic [7:0] b, output logic [7:0] r);
        for (int i = 7; i >= 0; i--) begin
            @(posedge clk_i);
            lk2.sclk <= 1'b0;
            lk2.mosi <= b[i];
            repeat (4) @(posedge clk_i);
            lk2.sclk <= 1'b1;
            repeat (3) @(posedge clk_i);
            r[i] = lk2.miso_line;
        end
    endtask
    // Mosi flips after deselect so a stale bit is never mistaken
    task frame(input logic [7:0] c, input int n);
        logic [7:0] r;
        @(posedge clk_i);
        lk2.serial_select_n <= 1'b0;
        sbyte(c, r);
        for (int k = 0; k < n; k++)
            sbyte(txb[k], rxb[k]);
        @(posedge clk_i);
        lk2.serial_select_n <= 1'b1;
        lk2.mosi <= ~lk2.mosi;
        repeat (8) @(posedge clk_i);
    endtask

    task t_power;
        pwr(1'b1);
        chkb("rst out", 1'b1, arst);
        chkb("arr", 1'b0, sup);
        rdc(`REG_ENABLE, `ENABLE_RST, "enable");
        rdc(`REG_KEY, `KEY_RD_LOCKED, "key");
    endtask
    task t_modes;
        wr(`REG_ENABLE, 8'h0e);
        chkb("arr", 1'b1, sup);
        chkb("led", 1'b0, led);
        wr(`REG_ENABLE, 8'h0f);
        chkb("arr", 1'b1, sup);
        chkb("led", 1'b1, led);
        wr(`REG_ENABLE, 8'h0d);
        chkb("arr", 1'b0, sup);
        chkb("led", 1'b0, led);
    endtask
    task t_lock;
        wr(`REG_PROT_LO, 8'h55);
        rdc(`REG_PROT_LO, 8'h00, "prot");
        wr(`REG_KEY, `KEY_FIRST);
        wr(7'h02, 8'h33);
        wr(`REG_KEY, `KEY_SECOND);
        rdc(`REG_KEY, `KEY_RD_LOCKED, "key");
        wr(`REG_KEY, `KEY_FIRST);
        wr(`REG_KEY, `KEY_SECOND);
        rdc(`REG_KEY, `KEY_RD_UNLOCKED, "key");
        wr(`REG_PROT_LO, 8'h55);
        rdc(`REG_PROT_LO, 8'h55, "prot");
        wr(`REG_KEY, `KEY_FIRST);
        rdc(`REG_KEY, `KEY_RD_UNLOCKED, "key");
        wr(`REG_KEY, 8'h00);
        rdc(`REG_KEY, `KEY_RD_LOCKED, "key");
        wr(`REG_PROT_HI, 8'h66);
        rdc(`REG_PROT_HI, 8'h00, "prot");
        wr(`REG_KEY, `KEY_FIRST);
        wr(`REG_KEY, `KEY_SECOND);
    endtask
    task t_irq;
        int n;
        logic [31:0] s;
        wr(`REG_ENABLE, 8'h0f);
        wr(`REG_MASK, 8'h00);
        flt[0] <= 1'b1;
        repeat (10) @(posedge clk_i);
        chkb("irq", 1'b0, lk.irq_out_n);
        wb(1'b0, `HOST_STATUS, 32'h0, s);
        chkb("irq flag", 1'b1, s[2]);
        chkb("led", 1'b1, led);
        rdc(`REG_STATUS, 8'h01, "status");
        chkb("irq", 1'b1, lk.irq_out_n);
        n = 0;
        while (lk.irq_out_n !== 1'b0 && n < 4000) begin
            @(posedge clk_i);
            n++;
        end
        chkb("repull", 1'b1, n > 100 && n <= 3200);
        flt[0] <= 1'b0;
        rdc(`REG_STATUS, 8'h01, "status");
        rdc(`REG_STATUS, 8'h00, "status");
        // Let the release window run out so masking is really seen
        wr(`REG_MASK, 8'h01);
        repeat (1700) @(posedge clk_i);
        flt[0] <= 1'b1;
        repeat (10) @(posedge clk_i);
        chkb("irq", 1'b1, lk.irq_out_n);
        flt[0] <= 1'b0;
        rdc(`REG_STATUS, 8'h01, "status");
    endtask
    task t_fault;
        for (int i = 2; i < 5; i++) begin
            wr(`REG_ENABLE, 8'h0f);
            flt[i] <= 1'b1;
            repeat (10) @(posedge clk_i);
            chkb("arr", 1'b0, sup);
            chkb("led", 1'b0, led);
            flt[i] <= 1'b0;
            rdc(`REG_ENABLE, 8'h0d, "enable");
        end
        flt[1] <= 1'b1;
        repeat (10) @(posedge clk_i);
        chkb("fast", 1'b1, fsd);
        flt[1] <= 1'b0;
        repeat (10) @(posedge clk_i);
        chkb("fast", 1'b1, fsd);
        pwr(1'b0);
        chkb("rst out", 1'b0, arst);
        chkb("irq", 1'b1, lk.irq_out_n);
        rdc(`REG_ENABLE, 8'hff, "off read");
        pwr(1'b1);
        chkb("fast", 1'b0, fsd);
        rdc(`REG_ENABLE, `ENABLE_RST, "enable");
        rdc(`REG_KEY, `KEY_RD_LOCKED, "key");
    endtask
    task t_burst;
        lk2.power_on_pin <= 1'b1;
        repeat (10) @(posedge clk_i);
        txb[0] = 8'h11;
        txb[1] = 8'h22;
        txb[2] = 8'h00;
        frame(8'h82, 2);
        frame(8'h02, 2);
        chk("burst", 8'h11, rxb[0]);
        chk("burst", 8'h22, rxb[1]);
        frame(8'h7f, 3);
        chk("wrap", `ENABLE_RST, rxb[2]);
    endtask

    // Main sequence
    initial begin
        lk2.sclk = 1'b1;
        lk2.serial_select_n = 1'b1;
        lk2.mosi = 1'b0;
        lk2.power_on_pin = 1'b0;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        t_power();
        t_modes();
        t_lock();
        t_irq();
        t_fault();
        t_burst();
        conclude();
    end
    // Watchdog: the sequence needs about 10k cycles
    initial begin
        #800000;
        mismatches++;
        conclude();
    end
endmodule
